// ### hdl/sysreg_pkg.sv
// Encodings, field positions and reset values for the patch and FP bank
package sysreg_pkg;
	localparam logic [1:0]  ENC_OP0_PATCH  = 2'h3;
	localparam logic [2:0]  ENC_OP1_PATCH  = 3'h6;
	localparam logic [3:0]  ENC_CRN_PATCH  = 4'hF;
	localparam logic [3:0]  ENC_CRM_PATCH  = 4'h8;
	localparam logic [2:0]  ENC_OP2_SELECT = 3'h0;
	localparam logic [2:0]  ENC_OP2_OPEXCL = 3'h4;
	localparam logic [2:0]  ENC_OP2_MKEXCL = 3'h5;
	localparam logic [2:0]  ENC_OP2_FLAGS  = 3'h6;
	localparam logic [1:0]  ENC_OP0_FPCTL  = 2'h3;
	localparam logic [2:0]  ENC_OP1_FPCTL  = 3'h3;
	localparam logic [3:0]  ENC_CRN_FPCTL  = 4'h4;
	localparam logic [3:0]  ENC_CRM_FPCTL  = 4'h4;
	localparam logic [2:0]  ENC_OP2_FPCTL  = 3'h0;
	localparam logic [1:0]  EL_TOP         = 2'h3;
	localparam int          FP_AHP_BIT     = 26;
	localparam int          FP_DN_BIT      = 25;
	localparam int          FP_FZ_BIT      = 24;
	localparam int          FP_RM_LSB      = 22;
	localparam int          FP_HALF_FLUSH_ENABLE_BIT    = 19;
	localparam logic [63:0] FP_WRITE_MASK  = 64'h0000_0000_07C8_0000;
	localparam logic [63:0] FP_RESET       = 64'h0000_0000_0000_0000;
	localparam logic [63:0] PATCH_RESET    = 64'h0000_0000_0000_0000;
	localparam logic [1:0]  RM_NEAREST     = 2'h0;
	localparam logic [1:0]  RM_PLUS_INF    = 2'h1;
	localparam logic [1:0]  RM_MINUS_INF   = 2'h2;
	localparam logic [1:0]  RM_ZERO        = 2'h3;
endpackage

// ### hdl/patch_entry.sv
// One patch entry: opcode exclusion, mask exclusion and flags words
`timescale 1ns/1ps
`default_nettype none
module patch_entry
	import sysreg_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Write strobes and data
	input  wire logic        wr_opexcl_i,
	input  wire logic        wr_mkexcl_i,
	input  wire logic        wr_flags_i,
	input  wire logic [63:0] wdata_i,
	// Stored words
	output logic      [63:0] opexcl_o,
	output logic      [63:0] mkexcl_o,
	output logic      [63:0] flags_o
);
	typedef struct packed {
		logic [63:0] opexcl;
		logic [63:0] mkexcl;
		logic [63:0] flags;
	} entry_state_t;

	entry_state_t state_reg;
	entry_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (wr_opexcl_i) begin
			state_next.opexcl = wdata_i;
		end
		if (wr_mkexcl_i) begin
			state_next.mkexcl = wdata_i;
		end
		if (wr_flags_i) begin
			state_next.flags = wdata_i;
		end
	end

	// No documented reset for these words; zero keeps them defined
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= {PATCH_RESET, PATCH_RESET, PATCH_RESET};
		end else begin
			state_reg <= state_next;
		end
	end

	assign opexcl_o = state_reg.opexcl;
	assign mkexcl_o = state_reg.mkexcl;
	assign flags_o  = state_reg.flags;
endmodule // patch_entry
`default_nettype wire

// ### hdl/fp_control.sv
// Floating-point control word and the per-operation mode outputs
`timescale 1ns/1ps
`default_nettype none
module fp_control
	import sysreg_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// Write port
	input  wire logic        wr_i,
	input  wire logic [63:0] wdata_i,
	// Operation class from the datapath
	input  wire logic        op_is_half_i,
	input  wire logic        op_is_half_cvt_i,
	// Stored word and effective controls
	output logic      [63:0] word_o,
	output logic             alt_half_format_sel_o,
	output logic             default_nan_enable_o,
	output logic             flush_denormal_enable_o,
	output logic             half_flush_enable_o,
	output logic             suppress_in_denorm_o,
	output logic      [1:0]  rounding_select_o
);
	typedef struct packed {
		logic [63:0] word;
	} fp_state_t;

	fp_state_t state_reg;
	fp_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (wr_i) begin
			state_next.word = wdata_i & FP_WRITE_MASK;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= FP_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign word_o = state_reg.word;
	// Only half conversions see the format select
	assign alt_half_format_sel_o = state_reg.word[FP_AHP_BIT]
		& op_is_half_cvt_i;
	assign default_nan_enable_o = state_reg.word[FP_DN_BIT];
	assign flush_denormal_enable_o = state_reg.word[FP_FZ_BIT]
		& ~op_is_half_i;
	assign half_flush_enable_o = state_reg.word[FP_HALF_FLUSH_ENABLE_BIT]
		& op_is_half_i;
	assign suppress_in_denorm_o = half_flush_enable_o;
	assign rounding_select_o = state_reg.word[FP_RM_LSB+1:FP_RM_LSB];

	property p_fz_half;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		op_is_half_i |-> !flush_denormal_enable_o;
	endproperty
	a_fz_half: assert property (p_fz_half)
		else $error("single flush bit reached a half operation");

	property p_reserved;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(word_o & ~FP_WRITE_MASK) == 64'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bits not zero");

	property p_write_lands;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		wr_i |=> word_o == ($past(wdata_i) & FP_WRITE_MASK);
	endproperty
	a_write_lands: assert property (p_write_lands)
		else $error("control write not visible next cycle");

	property p_ahp_cvt;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		!op_is_half_cvt_i |-> !alt_half_format_sel_o;
	endproperty
	a_ahp_cvt: assert property (p_ahp_cvt)
		else $error("alternative format outside conversion");

	property p_rm;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		wr_i |=> rounding_select_o == $past(wdata_i[FP_RM_LSB+1:FP_RM_LSB]);
	endproperty
	a_rm: assert property (p_rm)
		else $error("rounding field not taken from write");
endmodule // fp_control
`default_nettype wire

// ### hdl/patch_fp_sysregs.sv
// System register bank: patch exclusion and flag entries, FP control
// Operation
// - Patch registers trap below level three
// - Opcode exclusion at op2 4, selected entry
// - Mask exclusion at op2 5, selected entry
// - Flags at op2 6, selected entry
// - Patch registers 64 bits, no meaning
// - FP control bits 63:27 read zero
// - Bit 26 picks alternative half format
// - Format select used only in conversions
// - Half arithmetic always uses IEEE format
// - Bit 25 forces default NaN results
// - Bit 24 enables flush to zero
// - Bit 24 ignores half-precision work
// - Bits 23:22 choose the rounding mode
// - Bit 19 half flush, no denormal flag
`timescale 1ns/1ps
`default_nettype none
module patch_fp_sysregs
	import sysreg_pkg::*;
#(
	parameter int ENTRIES = 4
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_b_i,
	// System register request from the pipeline
	input  wire logic        req_valid_i,
	input  wire logic        req_write_i,
	input  wire logic [1:0]  req_el_i,
	input  wire logic [1:0]  req_op0_i,
	input  wire logic [2:0]  req_op1_i,
	input  wire logic [3:0]  req_crn_i,
	input  wire logic [3:0]  req_crm_i,
	input  wire logic [2:0]  req_op2_i,
	input  wire logic [63:0] req_wdata_i,
	// Answer
	output logic             rsp_valid_o,
	output logic             rsp_undef_o,
	output logic      [63:0] rsp_rdata_o,
	// Operation class from the FP datapath
	input  wire logic        op_is_half_i,
	input  wire logic        op_is_half_cvt_i,
	// Controls to the FP datapath
	output logic             alt_half_format_sel_o,
	output logic             default_nan_enable_o,
	output logic             flush_denormal_enable_o,
	output logic             half_flush_enable_o,
	output logic             suppress_in_denorm_o,
	output logic      [1:0]  rounding_select_o
);
	localparam int SEL_W = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	// Entry index is at most eight bits wide
	if (ENTRIES < 1 || ENTRIES > 256) begin : g_bad_entries
		$error("ENTRIES must be 1..256");
	end

	typedef enum logic [2:0] {
		DEC_NONE,
		DEC_SELECT,
		DEC_OPEXCL,
		DEC_MKEXCL,
		DEC_FLAGS,
		DEC_FPCTL
	} dec_t;

	typedef struct packed {
		logic [63:0] select;
		logic        rsp_valid;
		logic        rsp_undef;
		logic [63:0] rsp_rdata;
	} top_state_t;

	top_state_t state_reg;
	top_state_t state_next;

	dec_t        dec;
	logic        patch_space;
	logic        is_patch;
	logic [SEL_W-1:0] sel_idx;
	logic        sel_ok;
	logic [63:0] fp_word;
	logic [63:0] opexcl_q [ENTRIES];
	logic [63:0] mkexcl_q [ENTRIES];
	logic [63:0] flags_q  [ENTRIES];
	logic        allow;
	logic        wr_fp;
	logic [ENTRIES-1:0] wr_op;
	logic [ENTRIES-1:0] wr_mk;
	logic [ENTRIES-1:0] wr_fl;

	assign patch_space = req_op0_i == ENC_OP0_PATCH
		&& req_op1_i == ENC_OP1_PATCH && req_crn_i == ENC_CRN_PATCH
		&& req_crm_i == ENC_CRM_PATCH;

	always_comb begin
		dec = DEC_NONE;
		if (patch_space) begin
			case (req_op2_i)
				ENC_OP2_SELECT: dec = DEC_SELECT;
				ENC_OP2_OPEXCL: dec = DEC_OPEXCL;
				ENC_OP2_MKEXCL: dec = DEC_MKEXCL;
				ENC_OP2_FLAGS:  dec = DEC_FLAGS;
				default:        dec = DEC_NONE;
			endcase
		end else if (req_op0_i == ENC_OP0_FPCTL && req_op1_i == ENC_OP1_FPCTL
			&& req_crn_i == ENC_CRN_FPCTL && req_crm_i == ENC_CRM_FPCTL
			&& req_op2_i == ENC_OP2_FPCTL) begin
			dec = DEC_FPCTL;
		end
	end

	assign is_patch = dec == DEC_SELECT || dec == DEC_OPEXCL
		|| dec == DEC_MKEXCL || dec == DEC_FLAGS;
	// Patch space needs the top level; FP control traps live elsewhere
	assign allow = dec == DEC_FPCTL
		|| (is_patch && req_el_i == EL_TOP);
	assign sel_idx = state_reg.select[SEL_W-1:0];
	assign sel_ok = state_reg.select < 64'(ENTRIES);
	assign wr_fp = req_valid_i && req_write_i && dec == DEC_FPCTL;

	genvar g;
	generate
		for (g = 0; g < ENTRIES; g++) begin : g_entry
			logic hit;
			assign hit = req_valid_i && req_write_i && allow && sel_ok
				&& sel_idx == SEL_W'(g);
			assign wr_op[g] = hit && dec == DEC_OPEXCL;
			assign wr_mk[g] = hit && dec == DEC_MKEXCL;
			assign wr_fl[g] = hit && dec == DEC_FLAGS;
			patch_entry u_entry (
				.ref_clk_i   (ref_clk_i),
				.rst_b_i     (rst_b_i),
				.wr_opexcl_i (wr_op[g]),
				.wr_mkexcl_i (wr_mk[g]),
				.wr_flags_i  (wr_fl[g]),
				.wdata_i     (req_wdata_i),
				.opexcl_o    (opexcl_q[g]),
				.mkexcl_o    (mkexcl_q[g]),
				.flags_o     (flags_q[g])
			);
		end
	endgenerate

	fp_control u_fp (
		.ref_clk_i               (ref_clk_i),
		.rst_b_i                 (rst_b_i),
		.wr_i                    (wr_fp),
		.wdata_i                 (req_wdata_i),
		.op_is_half_i            (op_is_half_i),
		.op_is_half_cvt_i        (op_is_half_cvt_i),
		.word_o                  (fp_word),
		.alt_half_format_sel_o   (alt_half_format_sel_o),
		.default_nan_enable_o    (default_nan_enable_o),
		.flush_denormal_enable_o (flush_denormal_enable_o),
		.half_flush_enable_o     (half_flush_enable_o),
		.suppress_in_denorm_o    (suppress_in_denorm_o),
		.rounding_select_o       (rounding_select_o)
	);

	always_comb begin
		state_next = state_reg;
		state_next.rsp_valid = req_valid_i;
		state_next.rsp_undef = 1'b0;
		state_next.rsp_rdata = 64'h0;
		if (req_valid_i) begin
			if (!allow) begin
				state_next.rsp_undef = 1'b1;
			end else if (req_write_i) begin
				if (dec == DEC_SELECT) begin
					state_next.select = req_wdata_i;
				end
			end else begin
				case (dec)
					DEC_SELECT: state_next.rsp_rdata = state_reg.select;
					DEC_OPEXCL: state_next.rsp_rdata = sel_ok
						? opexcl_q[sel_idx] : 64'h0;
					DEC_MKEXCL: state_next.rsp_rdata = sel_ok
						? mkexcl_q[sel_idx] : 64'h0;
					DEC_FLAGS:  state_next.rsp_rdata = sel_ok
						? flags_q[sel_idx] : 64'h0;
					DEC_FPCTL:  state_next.rsp_rdata = fp_word;
					default:    state_next.rsp_rdata = 64'h0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rsp_valid_o = state_reg.rsp_valid;
	assign rsp_undef_o = state_reg.rsp_undef;
	assign rsp_rdata_o = state_reg.rsp_rdata;

	property p_undef_low_el;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && is_patch && req_el_i != EL_TOP)
			|=> rsp_valid_o && rsp_undef_o && rsp_rdata_o == 64'h0;
	endproperty
	a_undef_low_el: assert property (p_undef_low_el)
		else $error("patch access below top level not refused");

	property p_top_ok;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && is_patch && req_el_i == EL_TOP) |=> !rsp_undef_o;
	endproperty
	a_top_ok: assert property (p_top_ok)
		else $error("top level patch access refused");

	property p_opexcl_rb;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && req_write_i && dec == DEC_OPEXCL && allow && sel_ok)
			##1 (req_valid_i && !req_write_i && dec == DEC_OPEXCL
			&& allow && sel_ok && $stable(state_reg.select))
			|=> rsp_rdata_o == $past(req_wdata_i, 2);
	endproperty
	a_opexcl_rb: assert property (p_opexcl_rb)
		else $error("opcode exclusion readback mismatch");

	property p_no_undef_wr;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && req_el_i != EL_TOP) |-> (wr_op | wr_mk | wr_fl) == '0;
	endproperty
	a_no_undef_wr: assert property (p_no_undef_wr)
		else $error("refused access changed a patch entry");

	// Answer path
	property p_rsp_follows;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		rsp_valid_o == $past(req_valid_i);
	endproperty
	a_rsp_follows: assert property (p_rsp_follows)
		else $error("answer not one cycle after request");

	property p_refused_no_data;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && !allow) |=> rsp_undef_o && rsp_rdata_o == 64'h0;
	endproperty
	a_refused_no_data: assert property (p_refused_no_data)
		else $error("refused access returned data");

	property p_select_write;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && req_write_i && allow && dec == DEC_SELECT)
			|=> state_reg.select == $past(req_wdata_i);
	endproperty
	a_select_write: assert property (p_select_write)
		else $error("select write at top level lost");

	property p_low_el_select;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && is_patch && req_el_i != EL_TOP)
			|=> $stable(state_reg.select);
	endproperty
	a_low_el_select: assert property (p_low_el_select)
		else $error("refused access changed the select word");

	property p_mkexcl_rb;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && req_write_i && dec == DEC_MKEXCL && allow && sel_ok)
			##1 (req_valid_i && !req_write_i && dec == DEC_MKEXCL
			&& allow && sel_ok && $stable(state_reg.select))
			|=> rsp_rdata_o == $past(req_wdata_i, 2);
	endproperty
	a_mkexcl_rb: assert property (p_mkexcl_rb)
		else $error("mask exclusion readback mismatch");

	property p_flags_rb;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && req_write_i && dec == DEC_FLAGS && allow && sel_ok)
			##1 (req_valid_i && !req_write_i && dec == DEC_FLAGS
			&& allow && sel_ok && $stable(state_reg.select))
			|=> rsp_rdata_o == $past(req_wdata_i, 2);
	endproperty
	a_flags_rb: assert property (p_flags_rb)
		else $error("flags readback mismatch");

	property p_sel_range;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && !req_write_i && allow && !sel_ok
			&& is_patch && dec != DEC_SELECT)
			|=> rsp_rdata_o == 64'h0;
	endproperty
	a_sel_range: assert property (p_sel_range)
		else $error("read past the last entry returned data");

	property p_fp_read;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		(req_valid_i && dec == DEC_FPCTL) |=> !rsp_undef_o
			&& (rsp_rdata_o & ~FP_WRITE_MASK) == 64'h0;
	endproperty
	a_fp_read: assert property (p_fp_read)
		else $error("control access refused or reserved bits set");

	property p_one_word;
		@(posedge ref_clk_i) disable iff (!rst_b_i)
		$onehot0({wr_op, wr_mk, wr_fl});
	endproperty
	a_one_word: assert property (p_one_word)
		else $error("one request wrote more than one patch word");
endmodule // patch_fp_sysregs
`default_nettype wire

// ### bench/pipe_model.sv
// Pipeline model that issues system register instructions
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
	// Clock
	input  wire logic        ref_clk_i,
	// Request
	output logic             req_valid_o,
	output logic             req_write_o,
	output logic      [1:0]  req_el_o,
	output logic      [15:0] req_enc_o,
	output logic      [63:0] req_wdata_o,
	// Answer
	input  wire logic        rsp_valid_i,
	input  wire logic        rsp_undef_i,
	input  wire logic [63:0] rsp_rdata_i
);
	logic        got_valid;
	logic        got_undef;
	logic [63:0] got_rdata;

	initial begin
		req_valid_o = 1'b0;
		req_write_o = 1'b0;
		req_el_o    = 2'h0;
		req_enc_o   = 16'h0;
		req_wdata_o = 64'h0;
	end

	// Called just after an edge; the request is taken at the next edge
	// and its answer is read just after it. The request stays up so a
	// second call can follow back to back; idle lowers it.
	task automatic issue(input logic w, input logic [1:0] el,
		input logic [15:0] enc, input logic [63:0] d);
		req_valid_o = 1'b1;
		req_write_o = w;
		req_el_o    = el;
		req_enc_o   = enc;
		req_wdata_o = d;
		@(posedge ref_clk_i);
		#1;
		got_valid   = rsp_valid_i;
		got_undef   = rsp_undef_i;
		got_rdata   = rsp_rdata_i;
	endtask

	// One quiet cycle; the bus shows noise while valid is low
	task automatic idle();
		req_valid_o = 1'b0;
		req_wdata_o = ~req_wdata_o;
		req_enc_o   = ~req_enc_o;
		@(posedge ref_clk_i);
		#1;
	endtask
endmodule // pipe_model
`default_nettype wire

// ### bench/patch_fp_sysregs_bench.sv
// Self-checking bench for the patch and FP control register bank
`timescale 1ns/1ps
`default_nettype none
module patch_fp_sysregs_bench;
	import sysreg_pkg::*;
	localparam int          NENT  = 4;
	localparam logic [15:0] E_FP  = {2'h3, 3'h3, 4'h4, 4'h4, 3'h0};
	localparam logic [63:0] FMASK = 64'h0000_0000_07C8_0000;
	localparam logic [15:0] E_CRM9 = {2'h3, 3'h6, 4'hF, 4'h9, 3'h4};

	logic        ref_clk_i;
	logic        rst_b_i;
	logic        req_valid;
	logic        req_write;
	logic [1:0]  req_el;
	logic [15:0] req_enc;
	logic [63:0] req_wdata;
	logic        rsp_valid;
	logic        rsp_undef;
	logic [63:0] rsp_rdata;
	logic        op_half;
	logic        op_cvt;
	logic [6:0]  ctl_out;
	logic [63:0] fp;
	logic [63:0] pm [0:NENT-1][0:2];
	logic [63:0] d;
	logic [63:0] sv;
	logic [1:0]  lvl;
	logic [2:0]  op2;
	int          seed;
	int          error_cnt;
	int          compares;

	pipe_model pipe_model_inst (.ref_clk_i(ref_clk_i),
		.req_valid_o(req_valid), .req_write_o(req_write),
		.req_el_o(req_el), .req_enc_o(req_enc), .req_wdata_o(req_wdata),
		.rsp_valid_i(rsp_valid), .rsp_undef_i(rsp_undef),
		.rsp_rdata_i(rsp_rdata));

	patch_fp_sysregs #(.ENTRIES(NENT)) patch_fp_sysregs_inst (
		.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
		.req_valid_i(req_valid), .req_write_i(req_write),
		.req_el_i(req_el), .req_op0_i(req_enc[15:14]),
		.req_op1_i(req_enc[13:11]), .req_crn_i(req_enc[10:7]),
		.req_crm_i(req_enc[6:3]), .req_op2_i(req_enc[2:0]),
		.req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid),
		.rsp_undef_o(rsp_undef), .rsp_rdata_o(rsp_rdata),
		.op_is_half_i(op_half), .op_is_half_cvt_i(op_cvt),
		.alt_half_format_sel_o(ctl_out[6]),
		.default_nan_enable_o(ctl_out[5]),
		.flush_denormal_enable_o(ctl_out[4]),
		.half_flush_enable_o(ctl_out[3]),
		.suppress_in_denorm_o(ctl_out[2]),
		.rounding_select_o(ctl_out[1:0]));

	always #25 ref_clk_i = ~ref_clk_i;

	function automatic logic [15:0] penc(input logic [2:0] op2);
		return {2'h3, 3'h6, 4'hF, 4'h8, op2};
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One instruction with the expected answer
	task automatic acc(input logic w, input logic [1:0] el,
		input logic [15:0] enc, input logic [63:0] wd,
		input logic undef, input logic [63:0] rd);
		pipe_model_inst.issue(w, el, enc, wd);
		pipe_model_inst.idle();
		chk({63'h0, pipe_model_inst.got_valid}, 64'h1);
		chk({63'h0, pipe_model_inst.got_undef}, {63'h0, undef});
		chk(pipe_model_inst.got_rdata, rd);
	endtask

	// Expected datapath controls for the word fp and the current class
	function automatic logic [6:0] exp_ctl();
		return {fp[26] & op_cvt, fp[25], fp[24] & ~op_half,
			fp[19] & op_half, fp[19] & op_half, fp[23:22]};
	endfunction

	// Datapath controls for each operation class
	task automatic ctl_check();
		for (int k = 0; k < 3; k++) begin
			op_half = (k > 0);
			op_cvt  = (k == 2);
			#1;
			chk(64'(ctl_out), 64'(exp_ctl()));
			@(posedge ref_clk_i);
			#1;
		end
	endtask

	task automatic finish_test();
		$display("Errors: %0d Compares: %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#(5000 * 50);
		error_cnt++;
		finish_test();
	end

	initial begin
		ref_clk_i = 1'b0;
		rst_b_i   = 1'b0;
		op_half   = 1'b0;
		op_cvt    = 1'b0;
		seed      = 32'h7A87;
		error_cnt = 0;
		compares  = 0;
		fp        = 64'h0;
		repeat (20) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		acc(1'b0, 2'h3, E_FP, 64'h0, 1'b0, 64'h0);
		ctl_check();
		for (int i = 0; i < 14; i++) begin
			d = {$random(seed), $random(seed)};
			if (i == 0) d = '1;
			if (i == 1) d = 64'h0;
			d[23:22] = i[1:0];
			lvl = 2'($random(seed));
			acc(1'b1, lvl, E_FP, d, 1'b0, 64'h0);
			fp = d & FMASK;
			ctl_check();
			acc(1'b0, 2'h3, E_FP, 64'h0, 1'b0, fp);
		end
		for (int e = 0; e <= NENT; e++) begin
			sv = (e < NENT) ? 64'(e) : 64'h9;
			acc(1'b1, 2'h3, penc(3'h0), sv, 1'b0, 64'h0);
			for (int r = 0; r < 3; r++)
				acc(1'b0, 2'h3, penc(3'(4 + r)), 64'h0, 1'b0, 64'h0);
			for (int r = 0; r < 3; r++) begin
				d = {$random(seed), $random(seed)};
				if (e < NENT) pm[e][r] = d;
				acc(1'b1, 2'h3, penc(3'(4 + r)), d, 1'b0, 64'h0);
			end
			acc(1'b0, 2'h3, penc(3'h0), 64'h0, 1'b0, sv);
		end
		// A valid entry is selected so refused writes would show
		acc(1'b1, 2'h3, penc(3'h0), 64'h1, 1'b0, 64'h0);
		for (int k = 0; k < 3; k++)
			for (int r = 0; r < 4; r++) begin
				sv = {$random(seed), $random(seed)};
				lvl = 2'(k);
				op2 = (r == 0) ? 3'h0 : 3'(3 + r);
				acc(1'b1, lvl, penc(op2), sv, 1'b1, 64'h0);
				acc(1'b0, lvl, penc(op2), 64'h0, 1'b1, 64'h0);
			end
		acc(1'b0, 2'h3, penc(3'h0), 64'h0, 1'b0, 64'h1);
		// Unmapped encodings are refused like low-level patch access
		acc(1'b1, 2'h3, penc(3'h7), '1, 1'b1, 64'h0);
		acc(1'b0, 2'h3, E_CRM9, 64'h0, 1'b1, 64'h0);
		for (int e = 0; e < NENT; e++) begin
			acc(1'b1, 2'h3, penc(3'h0), 64'(e), 1'b0, 64'h0);
			for (int r = 0; r < 3; r++)
				acc(1'b0, 2'h3, penc(3'(4 + r)), 64'h0, 1'b0, pm[e][r]);
		end
		// Each read follows its write in the very next cycle
		for (int r = 0; r < 3; r++) begin
			d = {$random(seed), $random(seed)};
			pipe_model_inst.issue(1'b1, 2'h3, penc(3'(4 + r)), d);
			pipe_model_inst.issue(1'b0, 2'h3, penc(3'(4 + r)), 64'h0);
			chk(pipe_model_inst.got_rdata, d);
		end
		d = {$random(seed), $random(seed)};
		pipe_model_inst.issue(1'b1, 2'h1, E_FP, d);
		pipe_model_inst.issue(1'b0, 2'h0, E_FP, 64'h0);
		pipe_model_inst.idle();
		fp = d & FMASK;
		chk(pipe_model_inst.got_rdata, fp);
		ctl_check();
		// Reset in mid-run returns the control word and entries to zero
		rst_b_i = 1'b0;
		repeat (3) @(posedge ref_clk_i);
		#1;
		rst_b_i = 1'b1;
		fp = 64'h0;
		ctl_check();
		acc(1'b0, 2'h3, penc(3'h4), 64'h0, 1'b0, 64'h0);
		acc(1'b0, 2'h3, E_FP, 64'h0, 1'b0, fp);
		finish_test();
	end
endmodule // patch_fp_sysregs_bench
`default_nettype wire
